//--- rtl/cch_top.sv
// Four-way mixed cache controller with setup register on a Wishbone slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
// Behaviour
// - 8 kbyte cache, or 4k cache plus RAM
// - Shared four-way store, two-way in split mode
// - Lines are four words, filled whole
// - 128 entries per way, index bits 10..4
// - Write-back or write-through chosen by configuration
// - Present flag one means line valid
// - Dirty flag set by write-back writes
// - 22-bit tag from bits 31..10 compared
// - Top three tag address bits stored zero
// - Power-on clears flags; manual reset keeps them
// - Line data never initialised by reset
// - Six hardware age bits per set, LRU victim
// - Normal-mode way 3 victim patterns
// - Normal-mode way 2 victim patterns
// - Normal-mode way 1 victim patterns
// - Normal-mode way 0 victim patterns
// - Split mode caches in ways 0, 1 only
// - Split victim from age bit 5
// - Power-on clears age bits; manual keeps them
// - Setup register reads back zero after resets
// - Bit 0 turns caching on
// - Bit 5 selects split mode
// - Flush clears flags and ages, reads zero
// - Policy bit one means write-through
module cch_top (
    input  wire logic                        clock_i,
    input  wire logic                        rst_b_i,        // Power-on reset
    input  wire logic                        manual_reset_i, // Synchronous manual reset
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [31:0]                 wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic                        cpu_req_i,
    input  wire logic                        cpu_we_i,
    input  wire logic                        cpu_cacheable_i,
    input  wire logic [cch_pkg::IDX_W-1:0]   cpu_index_i,
    input  wire logic [31:0]                 cpu_paddr_i,
    input  wire logic [3:0]                  cpu_sel_i,
    input  wire logic [31:0]                 cpu_wdata_i,
    output logic      [31:0]                 cpu_rdata_o,
    output logic                             cpu_ready_o,
    output logic                             mem_cyc_o,
    output logic                             mem_we_o,
    output logic      [31:0]                 mem_adr_o,
    output logic      [3:0]                  mem_sel_o,
    output logic      [31:0]                 mem_dat_o,
    input  wire logic [31:0]                 mem_dat_i,
    input  wire logic                        mem_ack_i,
    output logic                             evict_o,
    output logic      [31:cch_pkg::IDX_LO]   evict_adr_o,
    output logic      [cch_pkg::LINE_W-1:0]  evict_line_o
);
    import cch_pkg::*;

    cch_state_t        state;                 // Controller state
    cch_state_t        next_state;
    logic              on_q;                  // Caching enabled
    logic              policy_q;              // Write-through when set
    logic              split_q;               // Two ways cache, two ways RAM
    logic [IDX_W-1:0]  idx_q;                 // Set of the current access
    logic [1:0]        beat_q;                // Fill word counter
    logic [1:0]        vway_q;                // Way being filled
    logic [SETS-1:0]   valid_q [WAYS];        // Present flags
    logic [SETS-1:0]   dirty_q [WAYS];        // Dirty flags
    logic [LRU_W-1:0]  lru_q [SETS];          // Age bits per set
    logic [TAG_W-1:0]  tag_rd [WAYS];         // Tag array read data
    logic [LINE_W-1:0] line_rd [WAYS];        // Line array read data
    logic [WAYS-1:0]   hit;                   // Per-way match
    logic [WAYS-1:0]   tag_we;
    logic [WAYS-1:0]   data_we;
    logic [1:0]        victim;
    logic [LRU_W-1:0]  next_lru;

    // Register decode; a write lands on the edge where ack is sampled
    wire        setup_sel = wb_adr_i == SETUP_ADDR;
    wire        bus_wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & setup_sel & wb_sel_i[0];
    wire        flush     = bus_wr & wb_dat_i[FLUSH_BIT];
    wire [31:0] setup_rd  = SETUP_RST | (32'(on_q) << ON_BIT) | (32'(policy_q) << POLICY_BIT)
                            | (32'(split_q) << SPLIT_BIT);

    // Lookup decode
    wire             look     = state == ST_LOOK;
    wire [3:0]       part     = split_q ? PART_SPLIT : PART_NORM;
    wire [TAG_W-1:0] tag_cmp  = {{SHADOW_W{1'h0}}, cpu_paddr_i[TAG_LO +: TAG_W - SHADOW_W]};
    wire             any_hit  = |hit;
    wire [1:0]       hit_way  = hit[0] ? WAY0 : hit[1] ? WAY1 : hit[2] ? WAY2 : WAY3;
    wire [1:0]       wsel     = cpu_paddr_i[WSEL_LO +: 2];
    wire [31:0]      hit_word = line_rd[hit_way][WORD_W * wsel +: WORD_W];
    wire [1:0]       acc_way  = look ? hit_way : vway_q;
    wire             hit_upd  = look & any_hit;
    wire             miss_fill = look & ~any_hit & (~cpu_we_i | ~policy_q);
    wire             vdirty   = valid_q[victim][idx_q] & dirty_q[victim][idx_q];
    wire             fill_ack = (state == ST_FILL) & mem_ack_i;
    wire             fill_last = fill_ack & (beat_q == LAST_BEAT);
    wire             lru_wr   = hit_upd | fill_last;
    wire             mem_done = (state == ST_MEM) & mem_ack_i;

    // Byte lanes of the processor word, merged into fill data on a write miss
    wire [31:0] byte_mask = {{8{cpu_sel_i[3]}}, {8{cpu_sel_i[2]}},
                             {8{cpu_sel_i[1]}}, {8{cpu_sel_i[0]}}};
    wire [31:0] merged    = (mem_dat_i & ~byte_mask) | (cpu_wdata_i & byte_mask);
    wire [31:0] fill_word = (cpu_we_i && beat_q == wsel) ? merged : mem_dat_i;
    wire [31:0] word_data = look ? cpu_wdata_i : fill_word;
    wire [1:0]  word_pos  = look ? wsel : beat_q;
    wire [31:0] word_mask = look ? byte_mask : 32'hffff_ffff;
    wire [LINE_W-1:0] data_mask = {{(LINE_W - WORD_W){1'h0}}, word_mask} << (WORD_W * word_pos);
    // Arrays are read with the new index while idle, then held on idx_q
    wire [IDX_W-1:0]  ram_addr  = (state == ST_IDLE) ? cpu_index_i : idx_q;

    // Per-way arrays: tag and line, neither initialised by reset
    for (genvar w = 0; w < WAYS; w++)
    begin : g_way
        assign hit[w]     = part[w] & valid_q[w][idx_q] & (tag_rd[w] == tag_cmp);
        assign tag_we[w]  = fill_last & (vway_q == 2'(w));
        assign data_we[w] = (hit_upd & cpu_we_i & (hit_way == 2'(w)))
                            | (fill_ack & (vway_q == 2'(w)));
        cch_ram #(.W(TAG_W), .D(SETS), .AW(IDX_W)) u_tag (
            .clock_i (clock_i),
            .addr_i  (ram_addr),
            .we_i    (tag_we[w]),
            .wmask_i ({TAG_W{1'h1}}),
            .wdata_i (tag_cmp),
            .rdata_o (tag_rd[w])
        );
        cch_ram #(.W(LINE_W), .D(SETS), .AW(IDX_W)) u_line (
            .clock_i (clock_i),
            .addr_i  (ram_addr),
            .we_i    (data_we[w]),
            .wmask_i (data_mask),
            .wdata_i ({BEATS{word_data}}),
            .rdata_o (line_rd[w])
        );
    end

    // Victim and age update for the current set
    cch_lru u_lru (
        .lru_i      (lru_q[idx_q]),
        .split_i    (split_q),
        .way_i      (acc_way),
        .victim_o   (victim),
        .next_lru_o (next_lru)
    );

    // Next state; uncached or disabled accesses go straight to memory
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (cpu_req_i && !cpu_ready_o)
                begin
                    next_state = (on_q && cpu_cacheable_i) ? ST_LOOK : ST_MEM;
                end
            end
            ST_LOOK:
            begin
                if (any_hit)
                begin
                    next_state = (cpu_we_i && policy_q) ? ST_MEM : ST_IDLE;
                end
                else
                begin
                    next_state = miss_fill ? ST_FILL : ST_MEM;
                end
            end
            ST_FILL: next_state = fill_last ? ST_IDLE : ST_FILL;
            ST_MEM:  next_state = mem_ack_i ? ST_IDLE : ST_MEM;
            default: next_state = ST_IDLE;
        endcase
    end

    // State register; manual reset abandons any access
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state <= ST_IDLE;
        else if (manual_reset_i)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Access bookkeeping; manual reset restarts the beat so a cut fill leaves no offset
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            idx_q  <= '0;
            beat_q <= 2'h0;
            vway_q <= WAY0;
        end
        else
        begin
            if (state == ST_IDLE)
                idx_q <= cpu_index_i;
            if (look || manual_reset_i)
            begin
                beat_q <= 2'h0;
                vway_q <= victim;
            end
            else if (fill_ack)
                beat_q <= beat_q + 2'h1;
        end
    end

    // Flags and ages: power-on reset and flush clear them, manual reset does not; a fill's set wins over flush
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int w = 0; w < WAYS; w++)
            begin
                valid_q[w] <= '0;
                dirty_q[w] <= '0;
            end
            for (int s = 0; s < SETS; s++)
                lru_q[s] <= LRU_RST;
        end
        else
        begin
            if (flush)
            begin
                for (int w = 0; w < WAYS; w++)
                begin
                    valid_q[w] <= '0;
                    dirty_q[w] <= '0;
                end
                for (int s = 0; s < SETS; s++)
                    lru_q[s] <= LRU_RST;
            end
            if (hit_upd && cpu_we_i && !policy_q)
                dirty_q[hit_way][idx_q] <= 1'h1;
            if (fill_last)
            begin
                valid_q[vway_q][idx_q] <= 1'h1;
                dirty_q[vway_q][idx_q] <= cpu_we_i;
            end
            if (lru_wr)
                lru_q[idx_q] <= next_lru;
        end
    end

    // Setup register: both resets clear it; reserved and flush bits read zero
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            on_q     <= SETUP_RST[ON_BIT];
            policy_q <= SETUP_RST[POLICY_BIT];
            split_q  <= SETUP_RST[SPLIT_BIT];
        end
        else if (manual_reset_i || bus_wr)
        begin
            on_q     <= manual_reset_i ? SETUP_RST[ON_BIT] : wb_dat_i[ON_BIT];
            policy_q <= manual_reset_i ? SETUP_RST[POLICY_BIT] : wb_dat_i[POLICY_BIT];
            split_q  <= manual_reset_i ? SETUP_RST[SPLIT_BIT] : wb_dat_i[SPLIT_BIT];
        end
    end

    // Bus slave: ack one cycle after strobe, unmapped reads return zero
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= (setup_sel && !wb_we_i) ? setup_rd : 32'h0;
        end
    end

    // Processor answer: one-cycle ready with registered data
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cpu_ready_o <= 1'h0;
            cpu_rdata_o <= 32'h0;
        end
        else
        begin
            cpu_ready_o <= ~manual_reset_i
                           & ((hit_upd & ~(cpu_we_i & policy_q)) | fill_last | mem_done);
            if (hit_upd)
                cpu_rdata_o <= hit_word;
            else if ((fill_ack && beat_q == wsel) || mem_done)
                cpu_rdata_o <= mem_dat_i;   // Word goes to the core as it fills
        end
    end

    // Dirty victim handed on as a whole line the cycle after lookup
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            evict_o      <= 1'h0;
            evict_adr_o  <= '0;
            evict_line_o <= '0;
        end
        else
        begin
            evict_o <= miss_fill & vdirty;
            if (miss_fill)
            begin
                evict_adr_o  <= {tag_rd[victim], idx_q[IDX_W-2:0]};
                evict_line_o <= line_rd[victim];
            end
        end
    end

    // External master: one word per cycle, idles one cycle between beats
    wire mem_start = ((next_state == ST_MEM) && (state != ST_MEM))
                     || ((next_state == ST_FILL) && (state != ST_FILL))
                     || ((state == ST_FILL) && !mem_cyc_o && !mem_ack_i);
    wire go_fill   = state != ST_MEM && next_state != ST_MEM;

    // Request register; fill beats always fetch whole words
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mem_cyc_o <= 1'h0;
            mem_we_o  <= 1'h0;
            mem_adr_o <= 32'h0;
            mem_sel_o <= 4'h0;
            mem_dat_o <= 32'h0;
        end
        else if (manual_reset_i || mem_ack_i)
            mem_cyc_o <= 1'h0;
        else if (mem_start)
        begin
            mem_cyc_o <= 1'h1;
            mem_we_o  <= go_fill ? 1'h0 : cpu_we_i;
            mem_adr_o <= go_fill ? {cpu_paddr_i[31:IDX_LO], beat_q, 2'h0} : cpu_paddr_i;
            mem_sel_o <= go_fill ? 4'hf : cpu_sel_i;
            mem_dat_o <= cpu_wdata_i;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    setup_reset_a: assert property (manual_reset_i |=> setup_rd == SETUP_RST)
        else $error("setup register not cleared");
    flush_clear_a: assert property (flush && !lru_wr |=>
        valid_q[0] == '0 && dirty_q[1] == '0 && lru_q[idx_q] == LRU_RST)
        else $error("flush left state behind");
    flush_read_a: assert property (wb_ack_o |-> !wb_dat_o[FLUSH_BIT])
        else $error("flush bit read back as one");
    victim_way3_a: assert property (look && !split_q && lru_q[idx_q] inside
        {6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34} |-> victim == WAY3)
        else $error("wrong victim for way 3 pattern");
    victim_way2_a: assert property (look && !split_q && lru_q[idx_q] inside
        {6'h01, 6'h03, 6'h0b, 6'h21, 6'h29, 6'h2b} |-> victim == WAY2)
        else $error("wrong victim for way 2 pattern");
    victim_way1_a: assert property (look && !split_q && lru_q[idx_q] inside
        {6'h06, 6'h07, 6'h0f, 6'h16, 6'h1e, 6'h1f} |-> victim == WAY1)
        else $error("wrong victim for way 1 pattern");
    victim_way0_a: assert property (look && !split_q && lru_q[idx_q] inside
        {6'h38, 6'h39, 6'h3b, 6'h3c, 6'h3e, 6'h3f} |-> victim == WAY0)
        else $error("wrong victim for way 0 pattern");
    split_victim_a: assert property (look && split_q |->
        victim == (lru_q[idx_q][P01] ? WAY0 : WAY1) && (hit & ~PART_SPLIT) == 4'h0)
        else $error("split mode used a wrong way");
    hit_read_a: assert property (hit_upd && !cpu_we_i && !manual_reset_i |=>
        cpu_ready_o && cpu_rdata_o == $past(hit_word))
        else $error("read hit not answered next cycle");
    tag_shadow_a: assert property (|tag_we |-> tag_cmp[TAG_W-1 -: SHADOW_W] == 3'h0)
        else $error("shadow bits stored in tag");
    fill_valid_a: assert property (fill_last |=> valid_q[$past(vway_q)][$past(idx_q)]
        && dirty_q[$past(vway_q)][$past(idx_q)] == $past(cpu_we_i))
        else $error("fill did not mark line present");
    wb_dirty_a: assert property (hit_upd && cpu_we_i && !policy_q |=>
        dirty_q[$past(hit_way)][$past(idx_q)])
        else $error("write-back hit left line clean");
    wt_write_a: assert property (hit_upd && cpu_we_i && policy_q && !manual_reset_i |=>
        mem_cyc_o && mem_we_o)
        else $error("write-through hit skipped memory");
    lru_recent_a: assert property (lru_wr && !split_q |=> victim != $past(acc_way))
        else $error("accessed way still chosen as victim");
endmodule : cch_top

//--- include/cch_pkg.sv
// Package with cache geometry, setup register layout and controller states
package cch_pkg;
    localparam int           WAYS       = 4;            // Ways in normal mode
    localparam int           SETS       = 128;          // Entries per way
    localparam int           IDX_W      = 7;            // Entry select width
    localparam int           IDX_LO     = 4;            // Entry select is address bits 10..4
    localparam int           TAG_LO     = 10;           // Tag is address bits 31..10
    localparam int           TAG_W      = 22;
    localparam int           SHADOW_W   = 3;            // Top address bits forced to zero in tags
    localparam int           WSEL_LO    = 2;            // Word select within a line
    localparam int           WORD_W     = 32;
    localparam int           LINE_W     = 128;          // Four 4-byte words
    localparam int           BEATS      = 4;
    localparam logic [1:0]   LAST_BEAT  = 2'h3;
    localparam int           LRU_W      = 6;
    localparam logic [5:0]   LRU_RST    = 6'h00;
    // Pairwise age bits: set means the lower-numbered way is the older one
    localparam int           P01        = 5;
    localparam int           P02        = 4;
    localparam int           P03        = 3;
    localparam int           P12        = 2;
    localparam int           P13        = 1;
    localparam int           P23        = 0;
    localparam logic [1:0]   WAY0       = 2'h0;
    localparam logic [1:0]   WAY1       = 2'h1;
    localparam logic [1:0]   WAY2       = 2'h2;
    localparam logic [1:0]   WAY3       = 2'h3;
    localparam logic [3:0]   PART_NORM  = 4'hf;         // Ways taking part in normal mode
    localparam logic [3:0]   PART_SPLIT = 4'h3;         // Ways taking part in split mode
    // Setup register
    localparam logic [31:0]  SETUP_ADDR = 32'h0fff_ffec;
    localparam logic [31:0]  SETUP_RST  = 32'h0000_0000;
    localparam int           ON_BIT     = 0;
    localparam int           POLICY_BIT = 1;
    localparam int           FLUSH_BIT  = 3;
    localparam int           SPLIT_BIT  = 5;
    typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_FILL, ST_MEM} cch_state_t;
endpackage : cch_pkg

//--- rtl/cch_ram.sv
// Single-port array with bit write mask and registered read, no reset
`timescale 1ns/100ps
module cch_ram #(
    parameter int W  = 32,
    parameter int D  = 128,
    parameter int AW = 7
) (
    input  wire logic          clock_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          we_i,
    input  wire logic [W-1:0]  wmask_i,
    input  wire logic [W-1:0]  wdata_i,
    output logic      [W-1:0]  rdata_o
);
    logic [W-1:0] mem [D];  // Contents stay unknown after any reset

    // Masked write, read data always from a register
    always_ff @(posedge clock_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= (mem[addr_i] & ~wmask_i) | (wdata_i & wmask_i);
        end
        rdata_o <= mem[addr_i];
    end
endmodule : cch_ram

//--- rtl/cch_lru.sv
// Victim choice and most-recent update for one set's six age bits
`timescale 1ns/100ps
module cch_lru (
    input  wire logic [cch_pkg::LRU_W-1:0] lru_i,
    input  wire logic                      split_i,
    input  wire logic [1:0]                way_i,
    output logic      [1:0]                victim_o,
    output logic      [cch_pkg::LRU_W-1:0] next_lru_o
);
    import cch_pkg::*;

    // A way is oldest when it is older than every other way
    wire       pick0 = lru_i[P01] & lru_i[P02] & lru_i[P03];
    wire       pick1 = ~lru_i[P01] & lru_i[P12] & lru_i[P13];
    wire       pick2 = ~lru_i[P02] & ~lru_i[P12] & lru_i[P23];
    wire [1:0] norm  = pick0 ? WAY0 : pick1 ? WAY1 : pick2 ? WAY2 : WAY3;
    // Two-way mode looks at the way 0/1 pair only
    assign victim_o = split_i ? (lru_i[P01] ? WAY0 : WAY1) : norm;

    // Accessed way becomes youngest of each pair it belongs to
    wire acc0 = way_i == WAY0;
    wire acc1 = way_i == WAY1;
    wire acc2 = way_i == WAY2;
    wire acc3 = way_i == WAY3;
    assign next_lru_o[P01] = acc0 ? 1'h0 : acc1 ? 1'h1 : lru_i[P01];
    assign next_lru_o[P02] = acc0 ? 1'h0 : acc2 ? 1'h1 : lru_i[P02];
    assign next_lru_o[P03] = acc0 ? 1'h0 : acc3 ? 1'h1 : lru_i[P03];
    assign next_lru_o[P12] = acc1 ? 1'h0 : acc2 ? 1'h1 : lru_i[P12];
    assign next_lru_o[P13] = acc1 ? 1'h0 : acc3 ? 1'h1 : lru_i[P13];
    assign next_lru_o[P23] = acc2 ? 1'h0 : acc3 ? 1'h1 : lru_i[P23];
endmodule : cch_lru

//--- tb/cch_mem.sv
// External memory model answering single-word cycles after 0 to 2 waits
`timescale 1ns/100ps
module cch_mem (
    input  wire logic        clock_i,
    input  wire logic        cyc_i,
    input  wire logic [31:0] adr_i,
    output logic      [31:0] dat_o,
    output logic             ack_o
);
    logic [1:0] wt = 2'h0;   // Wait states left before the next answer
    initial ack_o = 1'b0;
    initial dat_o = 32'h0;
    // Stale data is inverted each cycle so a late sample never matches
    always @(posedge clock_i)
    begin
        ack_o <= cyc_i && !ack_o && wt == 2'h0;
        dat_o <= (cyc_i && !ack_o && wt == 2'h0) ? adr_i ^ 32'h5a5a_a5a5 : ~dat_o;
        if (cyc_i && !ack_o)
            wt <= (wt == 2'h0) ? {1'b0, adr_i[2]} + {1'b0, adr_i[3]} : wt - 2'h1;
    end
endmodule : cch_mem

//--- tb/cch_top_tb.sv
// Self-checking bench: setup register, fills, evictions, resets and modes
`timescale 1ns/100ps
module cch_top_tb;
    import cch_pkg::*;
    logic         clock_i = 0, rst_b_i = 0, mrst = 0, cyc = 0, we = 0, req = 0, cwe = 0;
    logic [31:0]  adr = 0, dat = 0, pa = 0, cwd = 0, wb_rd, c_rd, m_adr, m_wd, m_rd, rd, wd, wr_dat;
    logic [31:0]  a [8];
    logic         ack, rdy, m_cyc, m_we, m_ack, ev;
    logic [3:0]   sel = 4'hf, m_sel;
    logic [31:4]  ev_adr, e_adr;
    logic [127:0] ev_line, e_line;
    logic [6:0]   idx;
    logic [17:0]  tag;
    int           fails = 0, num_checks = 0, beats = 0, n_ev = 0, b0;
    integer       seed = 47145;
    always #50 clock_i = ~clock_i;
    cch_top DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .manual_reset_i(mrst),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_rd), .wb_ack_o(ack), .cpu_req_i(req), .cpu_we_i(cwe),
        .cpu_cacheable_i(1'b1), .cpu_index_i(pa[10:4]), .cpu_paddr_i(pa), .cpu_sel_i(4'hf),
        .cpu_wdata_i(cwd), .cpu_rdata_o(c_rd), .cpu_ready_o(rdy), .mem_cyc_o(m_cyc),
        .mem_we_o(m_we), .mem_adr_o(m_adr), .mem_sel_o(m_sel), .mem_dat_o(m_wd),
        .mem_dat_i(m_rd), .mem_ack_i(m_ack), .evict_o(ev), .evict_adr_o(e_adr),
        .evict_line_o(e_line));
    cch_mem mem (.clock_i(clock_i), .cyc_i(m_cyc), .adr_i(m_adr), .dat_o(m_rd), .ack_o(m_ack));
    // Count memory beats and keep the last dirty line handed out
    always @(posedge clock_i)
    begin
        if (m_cyc === 1'b1 && m_ack === 1'b1) beats <= beats + 1;
        if (m_cyc === 1'b1 && m_ack === 1'b1 && m_we === 1'b1) wr_dat <= m_wd;
        if (ev === 1'b1)
        begin
            n_ev    <= n_ev + 1;
            ev_adr  <= e_adr;
            ev_line <= e_line;
        end
    end
    function automatic logic [31:0] exp_w(input logic [31:0] x);
        return x ^ 32'h5a5a_a5a5;
    endfunction : exp_w
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // One bus access or one processor access; a hang ends the run as a failure
    task automatic acc(input logic bus, input logic w, input logic [31:0] x, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        if (bus) {cyc, we, adr, dat} <= {1'b1, w, x, d};
        else {req, cwe, pa, cwd} <= {1'b1, w, x, d};
        for (n = 0; n < 80 && !(bus ? ack === 1'b1 : rdy === 1'b1); n++) @(posedge clock_i);
        fails += (n == 80);
        if (n == 80) final_report();
        rd = bus ? wb_rd : c_rd;
        {cyc, req} <= 2'b00;
    endtask : acc
    initial
    begin
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        acc(1, 0, SETUP_ADDR, 0);
        chk(rd, SETUP_RST);
        acc(1, 0, 32'h0000_0100, 0);
        chk(rd, 32'h0);
        acc(1, 1, SETUP_ADDR, 32'h0000_0009);
        acc(1, 0, SETUP_ADDR, 0);
        chk(rd, 32'h1);
        $display("setup test done");
        idx = 7'($random(seed));
        tag = 18'($random(seed));
        for (int k = 0; k < 8; k++) a[k] = {3'h0, tag + 18'(k), idx, 2'(k), 2'h0};
        b0 = beats;
        for (int k = 0; k < 4; k++)
        begin
            acc(0, 0, a[k], 0);
            chk(rd, exp_w(a[k]));
        end
        chk(32'(beats - b0), 32'd16);
        wd = $random(seed);
        acc(0, 1, a[0], wd);
        chk(32'(beats - b0), 32'd16);
        for (int k = 4; k < 7; k++) acc(0, 0, a[k], 0);
        chk(32'(n_ev), 32'd0);
        acc(0, 0, a[7], 0);
        chk(32'(n_ev), 32'd1);
        chk({ev_adr, 4'h0}, {a[0][31:4], 4'h0});
        chk(ev_line[31:0], wd);
        $display("replacement test done");
        mrst <= 1'b1;
        @(posedge clock_i);
        mrst <= 1'b0;
        acc(1, 0, SETUP_ADDR, 0);
        chk(rd, SETUP_RST);
        b0 = beats;
        acc(0, 0, a[7], 0);
        chk(rd, exp_w(a[7]));
        chk(32'(beats - b0), 32'd1);
        acc(1, 1, SETUP_ADDR, 32'h1);
        b0 = beats;
        acc(0, 0, a[7], 0);
        chk(32'(beats - b0), 32'd0);
        chk(rd, exp_w(a[7]));
        $display("manual reset test done");
        acc(1, 1, SETUP_ADDR, 32'h0000_0029);
        acc(1, 0, SETUP_ADDR, 0);
        chk(rd, 32'h21);
        for (int k = 0; k < 3; k++) acc(0, 0, a[k], 0);
        b0 = beats;
        acc(0, 0, a[1], 0);
        chk(32'(beats - b0), 32'd0);
        acc(0, 0, a[0], 0);
        chk(32'(beats - b0), 32'd4);
        acc(1, 1, SETUP_ADDR, 32'h0000_000b);
        b0 = beats;
        acc(0, 1, a[3], wd);
        chk(32'(beats - b0), 32'd1);
        chk(wr_dat, wd);
        acc(0, 0, a[3], 0);
        chk(32'(beats - b0), 32'd5);
        acc(0, 1, a[3], ~wd);
        chk(32'(beats - b0), 32'd6);
        chk(wr_dat, ~wd);
        acc(0, 0, a[3], 0);
        chk(rd, ~wd);
        $display("mode test done");
        final_report();
    end
endmodule : cch_top_tb
